// ### src/nfc_ctrl.sv
// Host sequencer for erase, reset, status and feature access of a NAND
// Assumes an AHB-Lite master, one flash on the pins, 25 MHz clock
`timescale 1ns/10ps
module nfc_ctrl
    import nfc_pkg::*;
(
    input wire logic clk_i,              // System clock
    input wire logic rst_i,              // Async reset, high
    input wire logic hsel_i,             // Slave select
    input wire logic [31:0] haddr_i,     // Address
    input wire logic [1:0] htrans_i,     // Transfer type
    input wire logic hwrite_i,           // Write not read
    input wire logic [2:0] hsize_i,      // Transfer size
    input wire logic [31:0] hwdata_i,    // Write data
    input wire logic hready_i,           // Bus ready
    output logic hreadyout_o,            // Slave ready
    output logic hresp_o,                // Response, always OKAY
    output logic [31:0] hrdata_o,        // Read data
    output logic ce_n_o,                 // Chip enable, low
    output logic cle_o,                  // Command latch enable
    output logic ale_o,                  // Address latch enable
    output logic we_n_o,                 // Write strobe, low
    output logic read_strobe_n_o,        // Read strobe, low
    output logic [7:0] io_o,             // Data bus out
    output logic io_oe_n_o,              // Data bus drive, low drives
    input wire logic [7:0] io_i,         // Data bus in
    input wire logic ready_busy_n_i      // Ready high, busy low
);
    logic [8:0] pins_sync;
    logic rb_sync;
    logic [7:0] io_sync;

    nfc_sync #(.W(9)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ready_busy_n_i, io_i}),
        .q_o(pins_sync)
    );
    assign rb_sync = pins_sync[8];
    assign io_sync = pins_sync[7:0];

    // Bus state
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [2:0] ctrl_code, next_ctrl_code;
    logic [23:0] row, next_row;
    logic [7:0] feat, next_feat;
    logic [31:0] param, next_param;
    logic done, next_done;
    logic refused, next_refused;
    logic [31:0] next_hrdata;
    // Sequencer state
    nfc_state_type state, next_state;
    nfc_op_type op, next_op;
    logic [1:0] idx, next_idx;
    logic ph, next_ph;
    logic [7:0] tmr, next_tmr;
    logic queued, next_queued;
    logic [7:0] status_byte, next_status_byte;
    logic [31:0] result, next_result;
    logic next_ce_n, next_cle, next_ale, next_we_n, next_rd_n, next_oe_n;
    logic [7:0] next_io;
    // Cross-group strobes
    logic start_req, accept, refuse, fin, wr_hit;
    logic [2:0] req_code;

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign wr_hit = wr_pend;
    assign req_code = hwdata_i[CTRL_OP_LSB +: 3];
    assign start_req = wr_hit && wr_addr == REG_CTRL && hwdata_i[CTRL_START];
    assign fin = state == S_FIN;
    assign refuse = start_req && !accept;

    // Number of address bytes an operation sends
    function automatic logic [1:0] addr_n(nfc_op_type o);
        case (o)
            OP_ERASE, OP_QUEUE, OP_STATUS_PLANE: addr_n = ROW_CYCLES;
            OP_GET_FEAT, OP_SET_FEAT: addr_n = FEAT_CYCLES;
            default: addr_n = 2'h0;
        endcase
    endfunction : addr_n

    // Last byte index within a strobing state
    function automatic logic [1:0] last_idx(nfc_state_type s,
                                            nfc_op_type o);
        case (s)
            S_ADDR: last_idx = 2'(addr_n(o) - 2'h1);
            S_WR: last_idx = PARAM_LAST;
            S_RD: last_idx = (o == OP_GET_FEAT) ? PARAM_LAST : 2'h0;
            default: last_idx = 2'h0;
        endcase
    endfunction : last_idx

    // Stage that follows a finished stage
    function automatic nfc_state_type step(nfc_state_type s,
                                           nfc_op_type o,
                                           logic [7:0] sb);
        case (s)
            S_CMD1: begin
                if (addr_n(o) != 2'h0) step = S_ADDR;
                else if (o == OP_RESET) step = S_WAIT;
                else step = S_RD;
            end
            S_ADDR: begin
                if (o == OP_ERASE || o == OP_QUEUE) step = S_CMD2;
                else if (o == OP_SET_FEAT) step = S_WR;
                else if (o == OP_STATUS_PLANE) step = S_RD;
                else step = S_WAIT;
            end
            S_CMD2, S_WR: step = S_WAIT;
            S_WAIT: begin
                if (o == OP_GET_FEAT) step = S_RD;
                else if (o == OP_SET_FEAT) step = S_FIN;
                else step = S_POLL_CMD;
            end
            S_POLL_CMD: step = S_POLL_RD;
            S_POLL_RD: begin
                // Queue waits for both ready bits before the next command
                if (sb[SB_READY] && (o != OP_QUEUE || sb[SB_ARRAY_READY]))
                    step = S_FIN;
                else
                    step = S_POLL_CMD;
            end
            default: step = S_FIN;
        endcase
    endfunction : step

    // Byte driven on the bus in a given stage
    function automatic logic [7:0] byte_out(nfc_state_type s,
                                            nfc_op_type o, logic [1:0] i,
                                            logic [23:0] r, logic [7:0] f,
                                            logic [31:0] p, logic q);
        logic [7:0] b;
        b = 8'h00;
        case (s)
            S_CMD1: begin
                case (o)
                    OP_ERASE, OP_QUEUE: b = CMD_ERASE_SETUP;
                    OP_RESET: b = CMD_RESET;
                    OP_GET_FEAT: b = CMD_GET_FEAT;
                    OP_SET_FEAT: b = CMD_SET_FEAT;
                    OP_STATUS_PLANE: b = CMD_STATUS_PLANE;
                    default: b = CMD_STATUS;
                endcase
            end
            S_CMD2: b = (o == OP_QUEUE) ? CMD_ERASE_QUEUE : CMD_ERASE_GO;
            S_POLL_CMD: b = CMD_STATUS;
            S_ADDR: begin
                if (o == OP_GET_FEAT || o == OP_SET_FEAT) begin
                    b = f;
                end else begin
                    b = r[{i, 3'h0} +: 8];
                    // Plane bit low when queueing, high when closing
                    if (i == 2'h0 && o == OP_QUEUE) b[PLANE_BIT] = 1'b0;
                    if (i == 2'h0 && o == OP_ERASE && q)
                        b[PLANE_BIT] = 1'b1;
                end
            end
            S_WR: b = p[{i, 3'h0} +: 8];
            default: b = 8'h00;
        endcase
        byte_out = b;
    endfunction : byte_out

    // Bus slave: address capture, register writes, read data
    always_comb begin
        next_wr_pend = hsel_i && hready_i && htrans_i[1] && hwrite_i &&
                       hsize_i == HSIZE_WORD;
        next_wr_addr = haddr_i[7:0];
        next_ctrl_code = ctrl_code;
        next_row = row;
        next_feat = feat;
        next_param = param;
        next_done = done;
        next_refused = refused;
        next_hrdata = hrdata_o;
        if (wr_hit) begin
            case (wr_addr)
                REG_CTRL: next_ctrl_code = req_code;
                REG_ROW: if (state == S_IDLE) next_row = hwdata_i[23:0];
                REG_FEAT: if (state == S_IDLE) next_feat = hwdata_i[7:0];
                REG_PARAM: if (state == S_IDLE) next_param = hwdata_i;
                REG_STATUS: begin
                    if (hwdata_i[ST_DONE]) next_done = 1'b0;
                    if (hwdata_i[ST_REFUSED]) next_refused = 1'b0;
                end
                default: next_done = done;
            endcase
        end
        // Setting beats clearing in the same cycle
        if (fin) next_done = 1'b1;
        if (refuse) next_refused = 1'b1;
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i[7:0])
                REG_CTRL: next_hrdata = {28'h0, ctrl_code, 1'b0};
                REG_ROW: next_hrdata = {8'h00, row};
                REG_FEAT: next_hrdata = {24'h0, feat};
                REG_PARAM: next_hrdata = param;
                REG_STATUS: next_hrdata = {16'h0, status_byte, 3'h0,
                                           rb_sync, queued, refused, done,
                                           state != S_IDLE};
                REG_RESULT: next_hrdata = result;
                default: next_hrdata = 32'h0;
            endcase
        end
    end

    // Register bus state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            ctrl_code <= 3'h0;
            row <= 24'h0;
            feat <= 8'h00;
            param <= 32'h0;
            done <= 1'b0;
            refused <= 1'b0;
            hrdata_o <= 32'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            ctrl_code <= next_ctrl_code;
            row <= next_row;
            feat <= next_feat;
            param <= next_param;
            done <= next_done;
            refused <= next_refused;
            hrdata_o <= next_hrdata;
        end
    end

    // Sequencer: stage walk, strobe timing, pin values
    always_comb begin
        next_state = state;
        next_op = op;
        next_idx = idx;
        next_ph = ph;
        next_tmr = tmr;
        next_queued = queued;
        next_status_byte = status_byte;
        next_result = result;
        // Reset may abort a busy flash; feature ops are refused while a queue is open
        accept = start_req && req_code <= OP_CODE_MAX &&
                 (state == S_IDLE || req_code == 3'(OP_RESET)) &&
                 !(queued && (req_code == 3'(OP_GET_FEAT) ||
                              req_code == 3'(OP_SET_FEAT)));
        if (accept) begin
            next_op = nfc_op_type'(req_code);
            next_state = S_CMD1;
            next_idx = 2'h0;
            next_ph = 1'b0;
            next_tmr = STROBE_TMR;
        end else if (state == S_FIN) begin
            next_state = S_IDLE;
            if (op == OP_QUEUE) next_queued = 1'b1;
            if (op == OP_ERASE || op == OP_RESET) next_queued = 1'b0;
        end else if (state == S_WAIT) begin
            // Wait for the busy pin to be valid, then for ready
            if (tmr != 8'h00) begin
                next_tmr = tmr - 8'h01;
            end else if (rb_sync) begin
                next_state = step(state, op, status_byte);
                // A read stage must also cover the synchroniser delay
                if (next_state == S_RD) next_tmr = RD_TMR;
                else next_tmr = STROBE_TMR;
            end
        end else if (state != S_IDLE) begin
            if (tmr != 8'h00) begin
                next_tmr = tmr - 8'h01;
            end else if (!ph) begin
                next_ph = 1'b1;
                next_tmr = STROBE_TMR;
                if (state == S_RD && op == OP_GET_FEAT)
                    next_result[{idx, 3'h0} +: 8] = io_sync;
                else if (state == S_RD || state == S_POLL_RD)
                    next_status_byte = io_sync;
            end else if (idx != last_idx(state, op)) begin
                next_idx = idx + 2'h1;
                next_ph = 1'b0;
                next_tmr = (state == S_RD) ? RD_TMR : STROBE_TMR;
            end else begin
                next_state = step(state, op, status_byte);
                next_idx = 2'h0;
                next_ph = 1'b0;
                if (next_state == S_WAIT) next_tmr = WB_TMR;
                else if (next_state == S_RD || next_state == S_POLL_RD)
                    next_tmr = RD_TMR;
                else next_tmr = STROBE_TMR;
            end
        end
        next_ce_n = next_state == S_IDLE;
        next_cle = next_state == S_CMD1 || next_state == S_CMD2 ||
                   next_state == S_POLL_CMD;
        next_ale = next_state == S_ADDR;
        next_oe_n = !(next_cle || next_ale || next_state == S_WR);
        next_we_n = next_oe_n || next_ph;
        next_rd_n = !((next_state == S_RD || next_state == S_POLL_RD) &&
                      !next_ph);
        next_io = byte_out(next_state, next_op, next_idx, row, feat, param,
                           queued);
    end

    // Register sequencer state and pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            op <= OP_ERASE;
            idx <= 2'h0;
            ph <= 1'b0;
            tmr <= 8'h00;
            queued <= 1'b0;
            status_byte <= 8'h00;
            result <= 32'h0;
            ce_n_o <= 1'b1;
            cle_o <= 1'b0;
            ale_o <= 1'b0;
            we_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            io_oe_n_o <= 1'b1;
            io_o <= 8'h00;
        end else begin
            state <= next_state;
            op <= next_op;
            idx <= next_idx;
            ph <= next_ph;
            tmr <= next_tmr;
            queued <= next_queued;
            status_byte <= next_status_byte;
            result <= next_result;
            ce_n_o <= next_ce_n;
            cle_o <= next_cle;
            ale_o <= next_ale;
            we_n_o <= next_we_n;
            read_strobe_n_o <= next_rd_n;
            io_oe_n_o <= next_oe_n;
            io_o <= next_io;
        end
    end

    // Checks on the pin sequences
    sequence s_setup;
        cle_o && !we_n_o && io_o == CMD_ERASE_SETUP;
    endsequence
    sequence s_addr_latch;
        ale_o && !we_n_o;
    endsequence
    property p_cle_ale;
        @(posedge clk_i) disable iff (rst_i) cle_o |-> !ale_o;
    endproperty
    a_cle_ale: assert property (p_cle_ale)
        else $error("command and address latch both high");
    property p_setup_then_addr;
        @(posedge clk_i) disable iff (rst_i)
            s_setup |-> ##[1:20] s_addr_latch;
    endproperty
    a_setup_then_addr: assert property (p_setup_then_addr)
        else $error("erase setup not followed by address");
    property p_drive_we;
        @(posedge clk_i) disable iff (rst_i) !we_n_o |-> !io_oe_n_o;
    endproperty
    a_drive_we: assert property (p_drive_we)
        else $error("write strobe with bus not driven");
    property p_read_float;
        @(posedge clk_i) disable iff (rst_i)
            !read_strobe_n_o |-> io_oe_n_o && we_n_o;
    endproperty
    a_read_float: assert property (p_read_float)
        else $error("bus driven during read strobe");
    property p_plane_lo;
        @(posedge clk_i) disable iff (rst_i)
            s_addr_latch and (op == OP_QUEUE && idx == 2'h0)
            |-> !io_o[PLANE_BIT];
    endproperty
    a_plane_lo: assert property (p_plane_lo)
        else $error("plane bit high on queued address");
    property p_plane_hi;
        @(posedge clk_i) disable iff (rst_i)
            s_addr_latch and (op == OP_ERASE && queued && idx == 2'h0)
            |-> io_o[PLANE_BIT];
    endproperty
    a_plane_hi: assert property (p_plane_hi)
        else $error("plane bit low on closing address");
    property p_wait_rb;
        @(posedge clk_i) disable iff (rst_i)
            state == S_WAIT && !rb_sync && !accept |=> state == S_WAIT;
    endproperty
    a_wait_rb: assert property (p_wait_rb)
        else $error("left busy wait while flash busy");
    property p_queue_ready;
        @(posedge clk_i) disable iff (rst_i)
            fin && op == OP_QUEUE |->
            status_byte[SB_READY] && status_byte[SB_ARRAY_READY];
    endproperty
    a_queue_ready: assert property (p_queue_ready)
        else $error("queue finished before both ready bits");
    property p_getf_ready;
        @(posedge clk_i) disable iff (rst_i)
            !read_strobe_n_o && op == OP_GET_FEAT |-> rb_sync;
    endproperty
    a_getf_ready: assert property (p_getf_ready)
        else $error("feature read while flash busy");
    property p_done_flag;
        @(posedge clk_i) disable iff (rst_i) fin |=> done && state == S_IDLE;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag not set after operation");
    property p_refuse;
        @(posedge clk_i) disable iff (rst_i)
            refuse |=> refused && $stable(state);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused order not flagged");
endmodule : nfc_ctrl

// ### src/nfc_pkg.sv
// Constants, types and register map of the erase/reset/feature host
// Assumes a 25 MHz clock and one byte-wide flash behind the pins
package nfc_pkg;
    // Clock and pin timing
    localparam int CLK_NS = 40;
    localparam int STROBE_NS = 40;      // Least strobe low or high time
    localparam int WB_NS = 100;         // Least wait before busy is valid
    localparam int SYNC_LAT = 2;        // Cycles through the synchroniser
    localparam int STROBE_RAW = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_RAW < 1) ? 1 : STROBE_RAW;
    localparam int WB_RAW = (WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int WB_CYC = (WB_RAW < 1) ? 1 : WB_RAW;
    localparam logic [7:0] STROBE_TMR = 8'(STROBE_CYC - 1);
    localparam logic [7:0] RD_TMR = 8'(STROBE_CYC - 1 + SYNC_LAT);
    localparam logic [7:0] WB_TMR = 8'(WB_CYC - 1 + SYNC_LAT);
    // Flash commands
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_ERASE_QUEUE = 8'hD1;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_PLANE = 8'h78;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
    localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
    // Feature addresses of the device outside
    localparam logic [7:0] FEAT_DRIVE = 8'h80;
    localparam logic [7:0] FEAT_PULLDOWN = 8'h81;
    // Status byte bits and row layout
    localparam int SB_FAIL = 0;
    localparam int SB_ARRAY_READY = 5;
    localparam int SB_READY = 6;
    localparam int PLANE_BIT = 6;       // Plane select in first row byte
    localparam logic [1:0] ROW_CYCLES = 2'h3;
    localparam logic [1:0] FEAT_CYCLES = 2'h1;
    localparam logic [1:0] PARAM_LAST = 2'h3;
    // Own register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ROW = 8'h04;
    localparam logic [7:0] REG_FEAT = 8'h08;
    localparam logic [7:0] REG_PARAM = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RESULT = 8'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_QUEUED = 3;
    localparam int ST_PIN_READY = 4;
    localparam int ST_BYTE_LSB = 8;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Operations software can order
    typedef enum logic [2:0] {
        OP_ERASE, OP_QUEUE, OP_RESET, OP_GET_FEAT, OP_SET_FEAT,
        OP_STATUS, OP_STATUS_PLANE
    } nfc_op_type;
    localparam logic [2:0] OP_CODE_MAX = 3'h6;
    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WR, S_WAIT, S_RD,
        S_POLL_CMD, S_POLL_RD, S_FIN
    } nfc_state_type;
endpackage : nfc_pkg

// ### src/nfc_sync.sv
// Two flip-flop synchroniser for levels arriving from the pins
// Assumes inputs change slowly against the clock
`timescale 1ns/10ps
module nfc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,          // System clock
    input wire logic rst_i,          // Async reset, high
    input wire logic [W-1:0] d_i,    // Asynchronous level
    output logic [W-1:0] q_o         // Synchronised level
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // Next values of both stages
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    // Register both stages
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule : nfc_sync

// ### verification/nfc_flash_model.sv
// Behavioural flash: erase, queue, reset, status and feature access
// Assumes pins from the host sequencer; busy times in ns, no clock
`timescale 1ns/10ps
module nfc_flash_model #(
    parameter int BUSY_NS = 400     // Shortened busy time of each op
) (
    input wire logic ce_n_i,        // Chip enable, low
    input wire logic cle_i,         // Command latch
    input wire logic ale_i,         // Address latch
    input wire logic we_n_i,        // Write strobe, low
    input wire logic read_strobe_n_i, // Read strobe, low
    input wire logic [7:0] d_i,     // Bus level
    output logic [7:0] q_o,         // Read byte
    output logic rb_n_o             // Ready high
);
    logic [7:0] cmd = 8'h00;
    logic [7:0] fa = 8'h00;
    logic [7:0] stat = 8'hE0;
    logic [31:0] feat [2] = '{default: '0};
    logic [23:0] row = '0;
    logic [23:0] first_row = '0;
    int n = 0;
    realtime done_at = 0;
    initial rb_n_o = 1'b1;
    initial q_o = 8'h00;
    // Busy window; a later op restarts it
    task automatic go_busy();
        done_at = $realtime + BUSY_NS;
        rb_n_o = 1'b0;
        stat[6:5] = 2'b00;
        fork
            begin
                #(BUSY_NS);
                if ($realtime >= done_at) begin
                    rb_n_o = 1'b1;
                    stat[6:5] = 2'b11;
                end
            end
        join_none
    endtask : go_busy
    // Bytes latched on the rising write strobe
    always @(posedge we_n_i) begin
        if (!ce_n_i && cle_i) begin
            cmd = d_i;
            n = 0;
            if (d_i == 8'hFF) stat = 8'hE0;
            if (d_i inside {8'hD0, 8'hD1, 8'hFF}) go_busy();
            if (d_i == 8'hD1) first_row = row;
        end else if (!ce_n_i && ale_i) begin
            row = {d_i, row[23:8]};
            fa = d_i;
            if (cmd == 8'hEE) go_busy();
        end else if (!ce_n_i && cmd == 8'hEF) begin
            if (fa[7:1] == 7'h40 && n == 0) feat[fa[0]] = {30'h0, d_i[1:0]};
            n++;
            if (n == 4) go_busy();
        end
    end
    // Read byte on the falling strobe; released bus shows the inverse
    always @(negedge read_strobe_n_i) begin
        if (cmd != 8'hEE) q_o = stat;
        else q_o = fa[7:1] == 7'h40 ? feat[fa[0]][8*n +: 8] : 8'h00;
        if (cmd == 8'hEE) n++;
    end
    always @(posedge read_strobe_n_i) q_o = ~q_o;
endmodule : nfc_flash_model

// ### verification/test_nfc_ctrl.sv
// Self-checking bench of the erase, reset and feature host
// Assumes one flash model on the pins and AHB-Lite single transfers
`timescale 1ns/10ps
module test_nfc_ctrl;
    import nfc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = '0;
    logic [31:0] hwdata_i = '0;
    logic [31:0] hrdata_o, q;
    logic hreadyout_o, hresp_o, ce_n_o, cle_o, ale_o, we_n_o, rd_n;
    logic io_oe_n_o, rb_n;
    logic [7:0] io_o, flash_q;
    logic [7:0] fa_t [3] = '{FEAT_DRIVE, FEAT_PULLDOWN, 8'h05};
    wire logic [7:0] io_lvl = io_oe_n_o ? flash_q : io_o;
    int mismatches = 0;
    int compares = 0;
    always #20 clk_i = ~clk_i;
    nfc_ctrl i_nfc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(HSIZE_WORD), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
        .read_strobe_n_o(rd_n), .io_o(io_o), .io_oe_n_o(io_oe_n_o),
        .io_i(io_lvl), .ready_busy_n_i(rb_n));
    nfc_flash_model i_nfc_flash_model (.ce_n_i(ce_n_o), .cle_i(cle_o),
        .ale_i(ale_o), .we_n_i(we_n_o), .read_strobe_n_i(rd_n), .d_i(io_lvl),
        .q_o(flash_q), .rb_n_o(rb_n));
    // One bus transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask : bus
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    // Start an op, poll until done or refused, then clear the flags
    task automatic run(input logic [2:0] op);
        int k;
        k = 0;
        bus(1'b1, REG_CTRL, {28'h0, op, 1'b1});
        do begin
            bus(1'b0, REG_STATUS, '0);
            k++;
        end while (q[ST_DONE] !== 1'b1 && q[ST_REFUSED] !== 1'b1 && k < 400);
        // A poll that runs out counts as a failure
        if (k >= 400) begin
            mismatches++;
            $display("BAD %0t operation never ended", $time);
        end
        bus(1'b1, REG_STATUS, 32'h6);
    endtask : run
    task automatic print_verdict();
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, REG_STATUS, '0);
        check(q & 32'hF, 32'h0);
        check({31'h0, hresp_o}, 32'h0);
        bus(1'b0, 8'h40, '0);
        check(q, 32'h0);
        bus(1'b1, REG_ROW, 32'h123405);
        run(3'h0);
        check(q & 32'hFF07, 32'hE002);
        check({8'h0, i_nfc_flash_model.row}, 32'h123405);
        bus(1'b1, REG_ROW, 32'h223445);
        run(3'h1);
        check(q & 32'hFF0F, 32'hE00A);
        run(3'h3);
        check(q & 32'h4, 32'h4);
        run(3'h0);
        check(q & 32'hFF0F, 32'hE002);
        check({8'h0, i_nfc_flash_model.first_row}, 32'h223405);
        check({8'h0, i_nfc_flash_model.row}, 32'h223445);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, REG_FEAT, {24'h0, fa_t[i]});
            bus(1'b1, REG_PARAM, i + 1);
            run(3'h4);
        end
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (10) @(posedge clk_i);
        bus(1'b0, REG_STATUS, '0);
        check(q & 32'h3, 32'h1);
        run(3'h2);
        check(q & 32'hFF03, 32'hE002);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, REG_FEAT, {24'h0, fa_t[i]});
            run(3'h3);
            bus(1'b0, REG_RESULT, '0);
            check(q, i < 2 ? i + 1 : 0);
        end
        run(3'h5);
        check(q & 32'hFF03, 32'hE002);
        run(3'h6);
        check(q & 32'hFF03, 32'hE002);
        run(3'h7);
        check(q & 32'h7, 32'h4);
        bus(1'b0, REG_CTRL, '0);
        check(q, 32'hE);
        print_verdict();
    end
endmodule : test_nfc_ctrl
